// ---- core/rsfc_hiccup.sv ----
// Hiccup off-timer that holds one converter off after a shutdown.
`timescale 1ns/1ps
module rsfc_hiccup
  import rsfc_pkg::*;
#(
  parameter int unsigned HICCUP_CYCLES = RSFC_HICCUP_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_trip,
  output logic o_hold_off
);
  logic [RSFC_CNT_W-1:0] cnt_reg;
  localparam logic [RSFC_CNT_W-1:0] LOAD = RSFC_CNT_W'(HICCUP_CYCLES);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      cnt_reg <= '0;
      o_hold_off <= 1'b0;
    end
    else if (i_trip)
    begin
      cnt_reg <= LOAD;
      o_hold_off <= 1'b1;
    end
    else if (cnt_reg != '0)
    begin
      cnt_reg <= cnt_reg - 1'b1;
      o_hold_off <= (cnt_reg != RSFC_CNT_W'(1));
    end
    else
      o_hold_off <= 1'b0;
  end
endmodule

// ---- core/rsfc_ocp_blank.sv ----
// Cycle-by-cycle over-current blanking for one converter.
`timescale 1ns/1ps
module rsfc_ocp_blank
  import rsfc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sw_tick,
  input wire logic i_oc,
  output logic o_blank
);
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [4:0] len_reg;
  logic [4:0] len_next;
  wire blanking = (cnt_reg != 5'h00);
  wire [4:0] len_dbl = (len_reg >= RSFC_BLANK_MAX) ? RSFC_BLANK_MAX : {len_reg[3:0], 1'b0};

  // The comparison is sampled only on a driven cycle; a clean cycle restarts the series.
  always_comb
  begin
    cnt_next = cnt_reg;
    len_next = len_reg;
    if (i_sw_tick)
    begin
      if (blanking)
        cnt_next = cnt_reg - 5'h01;
      else if (i_oc)
      begin
        cnt_next = len_reg;
        len_next = len_dbl;
      end
      else
        len_next = RSFC_BLANK_FIRST;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      cnt_reg <= 5'h00;
      len_reg <= RSFC_BLANK_FIRST;
      o_blank <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      len_reg <= len_next;
      o_blank <= (cnt_next != 5'h00);
    end
  end
endmodule

// ---- core/rsfc_pkg.sv ----
// Package with constants and carrier types of the rail sequencing and fault control block.
package rsfc_pkg;
  localparam int unsigned RSFC_CLK_MHZ = 50;
  // Times in microseconds and the cycle counts derived from them.
  localparam int unsigned RSFC_SS_TIME_US = 1500;
  localparam int unsigned RSFC_SEQ_GAP_US = 1000;
  localparam int unsigned RSFC_PWRUP_DCH_US = 100;
  localparam int unsigned RSFC_HICCUP_OFF_US = 5000;
  localparam int unsigned RSFC_SS_CYCLES = RSFC_SS_TIME_US * RSFC_CLK_MHZ;
  localparam int unsigned RSFC_GAP_CYCLES = RSFC_SEQ_GAP_US * RSFC_CLK_MHZ;
  localparam int unsigned RSFC_PWRUP_CYCLES = RSFC_PWRUP_DCH_US * RSFC_CLK_MHZ;
  localparam int unsigned RSFC_HICCUP_CYCLES = RSFC_HICCUP_OFF_US * RSFC_CLK_MHZ;
  localparam int unsigned RSFC_CNT_W = 24;
  // Over-current blanking lengths in switching cycles.
  localparam logic [4:0] RSFC_BLANK_FIRST = 5'h01;
  localparam logic [4:0] RSFC_BLANK_MAX = 5'h10;
  // Register byte offsets.
  localparam logic [7:0] RSFC_OFS_ENABLE = 8'h00;
  localparam logic [7:0] RSFC_OFS_FAULT_STATUS_FIRST = 8'h04;
  localparam logic [7:0] RSFC_OFS_FAULT_STATUS_SECOND = 8'h08;
  localparam logic [7:0] RSFC_OFS_STATE = 8'h0C;
  // Field positions.
  localparam int unsigned RSFC_EN_RAIL_LSB = 0;
  localparam int unsigned RSFC_EN_USB_LSB = 3;
  localparam int unsigned RSFC_ST1_BROWNOUT = 0;
  localparam int unsigned RSFC_ST1_HOT = 1;
  localparam int unsigned RSFC_ST1_TSD = 2;
  localparam int unsigned RSFC_ST1_UNDERVOLTAGE_LOCKOUT = 3;
  localparam int unsigned RSFC_ST2_PGOOD_LSB = 0;
  localparam int unsigned RSFC_ST2_USB_LSB = 3;
  localparam logic [4:0] RSFC_ENABLE_RST = 5'h00;
  localparam logic [3:0] RSFC_FAULT_STATUS_FIRST_RST = 4'h0;
  localparam logic [4:0] RSFC_FAULT_STATUS_SECOND_RST = 5'h00;
  localparam logic [31:0] RSFC_WB_ZERO = 32'h0000_0000;

  // Analogue comparator outputs, all active high.
  typedef struct packed {
    logic main_lt_9v3;
    logic main_gt_10v8;
    logic main_lt_4v7;
    logic reg_lt_4v25;
    logic usb_lt_3v9;
    logic temp_warn;
    logic temp_trip;
    logic temp_cool;
  } rsfc_sense_t;

  typedef enum {RSFC_S_PWRUP, RSFC_S_IDLE, RSFC_S_RAMP, RSFC_S_GAP} rsfc_seq_t;
endpackage

// ---- core/rsfc_top.sv ----
// Rail sequencing, fault control and register file of the power manager.
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
module rsfc_top
  import rsfc_pkg::*;
#(
  parameter int unsigned SS_CYCLES = RSFC_SS_CYCLES,
  parameter int unsigned GAP_CYCLES = RSFC_GAP_CYCLES,
  parameter int unsigned PWRUP_CYCLES = RSFC_PWRUP_CYCLES,
  parameter int unsigned HICCUP_CYCLES = RSFC_HICCUP_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_bus_mode,
  input wire rsfc_sense_t i_sense,
  input wire logic [2:0] i_rail_enable_input,
  input wire logic [2:0] i_sw_tick,
  input wire logic [2:0] i_rail_oc,
  input wire logic [2:0] i_rail_uv,
  input wire logic [1:0] i_usb_oc,
  input wire logic i_usb1_enable_or_bus_clock,
  input wire logic i_usb2_enable_or_bus_data,
  input wire logic i_usb1_fault_or_vscale_pin,
  output logic o_usb1_fault_or_vscale_pin,
  output logic o_usb1_fault_or_vscale_oe,
  output logic o_usb2_fault_or_irq_pin,
  output logic o_usb2_fault_or_irq_oe,
  output logic o_supply_temp_warning_n,
  output logic o_supply_temp_warning_oe,
  output logic [2:0] o_rail_on,
  output logic [2:0] o_rail_hs_allow,
  output logic o_en_discharge,
  output logic o_ss_charge,
  output logic o_ss_discharge,
  output logic [1:0] o_usb_on,
  output logic o_vscale_active,
  output logic o_irq
);
  localparam logic [RSFC_CNT_W-1:0] SS_LOAD = RSFC_CNT_W'(SS_CYCLES);
  localparam logic [RSFC_CNT_W-1:0] GAP_LOAD = RSFC_CNT_W'(GAP_CYCLES);
  localparam logic [RSFC_CNT_W-1:0] PWRUP_LOAD = RSFC_CNT_W'(PWRUP_CYCLES);

  // Hysteresis latch: set has priority, clear only when the set condition is gone.
  function automatic logic hyst(input logic state, input logic set, input logic clr);
    hyst = set | (state & ~clr);
  endfunction

  // Lowest numbered pending rail, which gives the fixed default order.
  function automatic logic [2:0] first_one(input logic [2:0] req);
    first_one = req[0] ? 3'b001 : (req[1] ? 3'b010 : (req[2] ? 3'b100 : 3'b000));
  endfunction

  rsfc_seq_t state_reg;
  rsfc_seq_t state_next;
  logic [RSFC_CNT_W-1:0] cnt_reg;
  logic [RSFC_CNT_W-1:0] cnt_next;
  logic [2:0] rail_on_reg;
  logic [2:0] rail_on_next;
  logic [4:0] enable_reg;
  logic [3:0] fault_status_first_reg;
  logic [4:0] fault_status_second_reg;
  logic bor_reg;
  logic tsd_reg;
  logic [1:0] usb_on_reg;
  logic [1:0] usb_flag_reg;
  logic warn_reg;
  logic hot_prev_reg;
  logic bor_prev_reg;
  logic tsd_prev_reg;
  logic undervoltage_lockout_prev_reg;
  logic [2:0] pg_prev_reg;
  logic [1:0] usbf_prev_reg;
  logic irq_reg;
  logic [2:0] blank;
  logic [2:0] hold_off;

  // Supply and temperature monitors; independent of any register access.
  wire bor_next = hyst(bor_reg, i_sense.main_lt_9v3, i_sense.main_gt_10v8);
  wire tsd_next = hyst(tsd_reg, i_sense.temp_trip, i_sense.temp_cool);
  wire warn_next = bor_next | i_sense.temp_warn | tsd_next;

  // Lockout decisions.
  wire rail_lock = i_sense.main_lt_4v7
    | (i_sense.reg_lt_4v25 & (rail_on_reg[1] | rail_on_reg[2]));
  wire usb_lock = i_sense.main_lt_9v3
    | (i_sense.usb_lt_3v9 & (usb_on_reg[0] | usb_on_reg[1]));
  wire any_undervoltage_lockout = rail_lock | usb_lock;
  wire all_lock = rail_lock | tsd_reg;
  wire undervoltage_lockout_event = i_bus_mode & any_undervoltage_lockout & ~undervoltage_lockout_prev_reg;
  wire tsd_event = i_bus_mode & tsd_reg & ~tsd_prev_reg;
  wire clr_enables = undervoltage_lockout_event | tsd_event;

  // Enable sources: rail pins always, rail bits only in bus mode; USB takes its bits in bus mode, its pins otherwise.
  wire [2:0] rail_src = i_rail_enable_input
    | (i_bus_mode ? enable_reg[RSFC_EN_RAIL_LSB +: 3] : 3'b000);
  wire [1:0] usb_src = i_bus_mode ? enable_reg[RSFC_EN_USB_LSB +: 2]
    : {i_usb2_enable_or_bus_data, i_usb1_enable_or_bus_clock};
  wire [2:0] rail_req = rail_src & ~hold_off & {3{~all_lock}};
  wire [2:0] pending = rail_req & ~rail_on_reg;
  wire [2:0] pick = first_one(pending);

  // Register access, one cycle per Wishbone request.
  wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire wb_wr = wb_req & i_wb_we & i_wb_sel[0] & i_bus_mode;
  wire wb_rd = wb_req & ~i_wb_we;
  wire hit_enable = (i_wb_adr == RSFC_OFS_ENABLE);
  wire hit_st1 = (i_wb_adr == RSFC_OFS_FAULT_STATUS_FIRST);
  wire hit_st2 = (i_wb_adr == RSFC_OFS_FAULT_STATUS_SECOND);
  wire hit_state = (i_wb_adr == RSFC_OFS_STATE);
  wire rd_clr1 = wb_rd & hit_st1 & i_bus_mode;
  wire rd_clr2 = wb_rd & hit_st2 & i_bus_mode;
  wire [31:0] rd_data;
  assign rd_data = hit_enable ? {27'h000_0000, enable_reg}
    : hit_st1 ? {28'h000_0000, fault_status_first_reg}
    : hit_st2 ? {27'h000_0000, fault_status_second_reg}
    : hit_state ? {22'h00_0000, i_bus_mode, warn_reg, tsd_reg, bor_reg, usb_on_reg,
                   state_reg == RSFC_S_RAMP, rail_on_reg}
    : RSFC_WB_ZERO;

  // Fault events for the status registers.
  wire hot_now = i_sense.temp_warn | tsd_reg;
  wire [3:0] st1_set = {undervoltage_lockout_event, tsd_event, hot_now & ~hot_prev_reg,
                        bor_reg & ~bor_prev_reg};
  wire [2:0] pg_fault = i_rail_uv & rail_on_reg;
  wire [4:0] st2_set = {i_usb_oc & ~usbf_prev_reg, pg_fault & ~pg_prev_reg};
  // Set wins over the read clear so that an event in the read cycle survives.
  wire [3:0] fault_status_first_next = st1_set | (rd_clr1 ? 4'h0 : fault_status_first_reg);
  wire [4:0] fault_status_second_next = st2_set | (rd_clr2 ? 5'h00 : fault_status_second_reg);

  wire [4:0] enable_wr = wb_wr & hit_enable ? i_wb_dat[4:0] : enable_reg;
  // A lockout clear beats a write in the same cycle: the safe side wins.
  wire [4:0] enable_next = clr_enables ? RSFC_ENABLE_RST : enable_wr;

  // Over-current blanking and hiccup per converter.
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_rail
      rsfc_ocp_blank u_blank
      (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_sw_tick(i_sw_tick[g] & rail_on_reg[g]),
        .i_oc(i_rail_oc[g]),
        .o_blank(blank[g])
      );
      rsfc_hiccup #(.HICCUP_CYCLES(HICCUP_CYCLES)) u_hiccup
      (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_trip(pg_fault[g]),
        .o_hold_off(hold_off[g])
      );
    end
  endgenerate

  // Start sequencer sharing one soft-start ramp among the three rails.
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    rail_on_next = rail_on_reg & rail_req;
    case (state_reg)
      RSFC_S_PWRUP:
      begin
        if (cnt_reg == '0)
          state_next = RSFC_S_IDLE;
        else
          cnt_next = cnt_reg - 1'b1;
      end
      RSFC_S_IDLE:
      begin
        if (pick != 3'b000)
        begin
          rail_on_next = rail_on_next | pick;
          state_next = RSFC_S_RAMP;
          cnt_next = SS_LOAD;
        end
      end
      RSFC_S_RAMP:
      begin
        if (cnt_reg == '0)
        begin
          state_next = RSFC_S_GAP;
          cnt_next = GAP_LOAD;
        end
        else
          cnt_next = cnt_reg - 1'b1;
      end
      RSFC_S_GAP:
      begin
        if (cnt_reg == '0)
          state_next = RSFC_S_IDLE;
        else
          cnt_next = cnt_reg - 1'b1;
      end
      default:
        state_next = RSFC_S_IDLE;
    endcase
    // Lockout discharges the enables and restarts the sequence from the top.
    if (all_lock)
    begin
      state_next = RSFC_S_IDLE;
      cnt_next = '0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_reg <= RSFC_S_PWRUP;
      cnt_reg <= PWRUP_LOAD;
      rail_on_reg <= 3'b000;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rail_on_reg <= rail_on_next;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      enable_reg <= RSFC_ENABLE_RST;
      fault_status_first_reg <= RSFC_FAULT_STATUS_FIRST_RST;
      fault_status_second_reg <= RSFC_FAULT_STATUS_SECOND_RST;
    end
    else
    begin
      enable_reg <= enable_next;
      fault_status_first_reg <= fault_status_first_next;
      fault_status_second_reg <= fault_status_second_next;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      bor_reg <= 1'b0;
      tsd_reg <= 1'b0;
      warn_reg <= 1'b0;
      hot_prev_reg <= 1'b0;
      bor_prev_reg <= 1'b0;
      tsd_prev_reg <= 1'b0;
      undervoltage_lockout_prev_reg <= 1'b0;
      pg_prev_reg <= 3'b000;
      usbf_prev_reg <= 2'b00;
    end
    else
    begin
      bor_reg <= bor_next;
      tsd_reg <= tsd_next;
      warn_reg <= warn_next;
      hot_prev_reg <= hot_now;
      bor_prev_reg <= bor_reg;
      tsd_prev_reg <= tsd_reg;
      undervoltage_lockout_prev_reg <= any_undervoltage_lockout;
      pg_prev_reg <= pg_fault;
      usbf_prev_reg <= i_usb_oc;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      usb_on_reg <= 2'b00;
      usb_flag_reg <= 2'b00;
      irq_reg <= 1'b0;
    end
    else
    begin
      usb_on_reg <= usb_src & {2{~usb_lock & ~tsd_reg}};
      usb_flag_reg <= i_usb_oc & usb_on_reg;
      irq_reg <= i_bus_mode & ((|fault_status_first_next) | (|fault_status_second_next));
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= RSFC_WB_ZERO;
    end
    else
    begin
      o_wb_ack <= wb_req;
      o_wb_dat <= wb_rd ? rd_data : RSFC_WB_ZERO;
    end
  end

  // Pin outputs.
  assign o_rail_on = rail_on_reg;
  assign o_rail_hs_allow = rail_on_reg & ~blank;
  assign o_en_discharge = (state_reg == RSFC_S_PWRUP) | all_lock;
  assign o_ss_charge = (state_reg == RSFC_S_RAMP);
  assign o_ss_discharge = (state_reg != RSFC_S_RAMP);
  assign o_usb_on = usb_on_reg;
  assign o_irq = irq_reg;
  assign o_supply_temp_warning_n = 1'b0;
  assign o_supply_temp_warning_oe = warn_reg;
  // In bus mode the second flag pin becomes a pushed, active-high interrupt.
  assign o_usb2_fault_or_irq_pin = i_bus_mode & irq_reg;
  assign o_usb2_fault_or_irq_oe = i_bus_mode | usb_flag_reg[1];
  assign o_usb1_fault_or_vscale_pin = 1'b0;
  assign o_usb1_fault_or_vscale_oe = ~i_bus_mode & usb_flag_reg[0];
  assign o_vscale_active = i_bus_mode & i_usb1_fault_or_vscale_pin;
endmodule

// ---- verif/rsfc_stage_model.sv ----
// Behavioural model of the three power stages: switching ticks, current and voltage sense.
`timescale 1ns/1ps
module rsfc_stage_model #(
  parameter int unsigned TICK_DIV = 4
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_oc_force,
  input wire logic [2:0] i_uv_force,
  output logic [2:0] o_sw_tick,
  output logic [2:0] o_rail_oc,
  output logic [2:0] o_rail_uv
);
  logic [3:0] div_reg;
  always_ff @(posedge i_clk)
  begin
    div_reg <= (!i_rst_n || div_reg == 4'(TICK_DIV - 1)) ? 4'h0 : div_reg + 4'h1;
  end
  // One switching cycle per divider wrap on every rail.
  assign o_sw_tick = {3{div_reg == 4'h0}};
  // Off the tick the comparator shows the opposite level, so off-tick sampling is caught.
  assign o_rail_oc = o_sw_tick[0] ? i_oc_force : ~i_oc_force;
  // Output undervoltage is raised only on demand, to start a hiccup cycle.
  assign o_rail_uv = i_uv_force;
endmodule

// ---- verif/rsfc_top_props.sv ----
// Port-level assertions for the rail sequencing and fault control block.
`timescale 1ns/1ps
module rsfc_top_props
  import rsfc_pkg::*;
#(
  parameter int unsigned SS_CYCLES = RSFC_SS_CYCLES,
  parameter int unsigned GAP_CYCLES = RSFC_GAP_CYCLES,
  parameter int unsigned PWRUP_CYCLES = RSFC_PWRUP_CYCLES,
  parameter int unsigned HICCUP_CYCLES = RSFC_HICCUP_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  input wire logic i_bus_mode,
  input wire rsfc_sense_t i_sense,
  input wire logic [2:0] i_rail_enable_input,
  input wire logic o_usb2_fault_or_irq_pin,
  input wire logic o_usb2_fault_or_irq_oe,
  input wire logic o_supply_temp_warning_oe,
  input wire logic [2:0] o_rail_on,
  input wire logic o_en_discharge,
  input wire logic o_ss_charge,
  input wire logic o_ss_discharge,
  input wire logic [1:0] o_usb_on,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  property p_ack_answer; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged");
  property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_rail_pin_off; !i_bus_mode && !i_rail_enable_input[0] |=> !o_rail_on[0]; endproperty
  a_rail_pin_off: assert property (p_rail_pin_off) else $error("rail on with pin low");
  property p_warn_set; i_sense.main_lt_9v3 || i_sense.temp_warn |=> o_supply_temp_warning_oe;
  endproperty
  a_warn_set: assert property (p_warn_set) else $error("warning not driven");
  // The trip is registered first, so the outputs fall on the second edge after the input.
  property p_thermal_off; i_sense.temp_trip |-> ##2 o_rail_on == 3'h0 && o_usb_on == 2'h0;
  endproperty
  a_thermal_off: assert property (p_thermal_off) else $error("output on in trip");
  property p_main_lockout; i_sense.main_lt_4v7 |=> o_rail_on == 3'h0; endproperty
  a_main_lockout: assert property (p_main_lockout) else $error("rail on in lockout");
  property p_usb_lockout; i_sense.main_lt_9v3 |=> o_usb_on == 2'h0; endproperty
  a_usb_lockout: assert property (p_usb_lockout) else $error("usb on in brownout");
  property p_en_hold; (i_sense.main_lt_4v7 || i_sense.temp_trip)[*2] |-> o_en_discharge;
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("enables not discharged");
  property p_ramp_len; $rose(o_ss_charge) |-> (o_ss_charge && !o_ss_discharge)[*8]; endproperty
  a_ramp_len: assert property (p_ramp_len) else $error("ramp cut short");
  property p_irq_pin;
    i_bus_mode[*2] |-> o_usb2_fault_or_irq_oe && o_usb2_fault_or_irq_pin == o_irq;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("irq pin not driven");
  c_all_rails: cover property (o_rail_on == 3'h7);
  c_irq: cover property ($rose(o_irq));
  c_trip: cover property (i_sense.temp_trip ##1 o_en_discharge);
endmodule
bind rsfc_top rsfc_top_props #(.SS_CYCLES(SS_CYCLES), .GAP_CYCLES(GAP_CYCLES),
  .PWRUP_CYCLES(PWRUP_CYCLES), .HICCUP_CYCLES(HICCUP_CYCLES)) u_rsfc_top_props (.*);

// ---- verif/tb.sv ----
// Self-checking testbench of the rail sequencing and fault control block.
`timescale 1ns/1ps
module tb
  import rsfc_pkg::*;
;
  localparam int SS = 20;
  localparam int GAP = 10;
  localparam int PWR = 5;
  localparam int HIC = 30;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic bus_mode = 1'b0;
  rsfc_sense_t sense = 8'h41;
  logic [2:0] ren = 3'h7;
  logic [2:0] oc_force = 3'h0;
  logic [2:0] uv_force = 3'h0;
  logic [1:0] usb_pin = 2'h0;
  logic [1:0] usb_oc = 2'h0;
  logic usb1_oe, usb2_oe, vscale;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack;
  logic [2:0] tick, rail_oc, rail_uv, rail_on, hs_allow;
  logic [1:0] usb_on;
  logic warn_oe, en_dis, irq;
  int failures = 0;
  int cmp_count = 0;
  always #10 clk = ~clk;
  rsfc_top #(.SS_CYCLES(SS), .GAP_CYCLES(GAP), .PWRUP_CYCLES(PWR), .HICCUP_CYCLES(HIC))
  u_rsfc_top (
    .i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_bus_mode(bus_mode), .i_sense(sense), .i_rail_enable_input(ren), .i_sw_tick(tick),
    .i_rail_oc(rail_oc), .i_rail_uv(rail_uv), .i_usb_oc(usb_oc),
    .i_usb1_enable_or_bus_clock(usb_pin[0]), .i_usb2_enable_or_bus_data(usb_pin[1]),
    .i_usb1_fault_or_vscale_pin(1'b1), .o_usb1_fault_or_vscale_pin(),
    .o_usb1_fault_or_vscale_oe(usb1_oe), .o_usb2_fault_or_irq_pin(),
    .o_usb2_fault_or_irq_oe(usb2_oe),
    .o_supply_temp_warning_n(), .o_supply_temp_warning_oe(warn_oe), .o_rail_on(rail_on),
    .o_rail_hs_allow(hs_allow), .o_en_discharge(en_dis), .o_ss_charge(), .o_ss_discharge(),
    .o_usb_on(usb_on), .o_vscale_active(vscale), .o_irq(irq));
  rsfc_stage_model u_rsfc_stage_model (.i_clk(clk), .i_rst_n(rst_n), .i_oc_force(oc_force),
    .i_uv_force(uv_force),
    .o_sw_tick(tick), .o_rail_oc(rail_oc), .o_rail_uv(rail_uv));

  task automatic conclude();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi)
    begin
      failures++;
      $display("ERROR t=%0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic timeout();
    failures++;
    conclude();
  endtask
  // Checks happen at the falling edge, so the design's updates have landed.
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Ack is judged at the rising edge; the request stands until then.
    for (n = 0; n < 50 && ack !== 1'b1; n++)
    begin
      @(posedge clk);
    end
    if (ack !== 1'b1) timeout();
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wait_rail(input int b, output int n);
    @(negedge clk);
    for (n = 1; rail_on[b] !== 1'b1; n++)
    begin
      @(negedge clk);
      if (n > 500) timeout();
    end
  endtask

  task automatic t_seq();
    int n;
    cycles(PWR - 1);
    chk(rail_on, 3'h0);
    chk(en_dis, 1'b1);
    wait_rail(0, n);
    wait_rail(1, n);
    chk_rng(n, SS + GAP, SS + GAP + 6);
    wait_rail(2, n);
    chk_rng(n, SS + GAP, SS + GAP + 6);
    cycles(SS + GAP + 5);
    @(posedge clk);
    ren <= 3'h0;
    cycles(3);
    chk(rail_on, 3'h0);
    @(posedge clk);
    ren <= 3'h4;
    wait_rail(2, n);
    chk_rng(n, 1, 4);
    @(posedge clk);
    ren <= 3'h7;
    wait_rail(0, n);
    chk_rng(n, SS + GAP - 3, SS + GAP + 6);
    wait_rail(1, n);
    chk_rng(n, SS + GAP, SS + GAP + 6);
    cycles(SS + GAP + 5);
  endtask
  task automatic t_ocp();
    int run, idx, k, j, n;
    int exp_run[5];
    exp_run = '{1, 2, 4, 8, 16};
    run = 0;
    idx = 0;
    @(posedge clk);
    ren <= 3'h1;
    oc_force <= 3'h1;
    for (k = 0; k < 60 && idx < 5; k++)
    begin
      @(negedge clk);
      for (j = 0; j < 4 && tick[0] !== 1'b1; j++) @(negedge clk);
      cycles(2);
      if (hs_allow[0] === 1'b0) run++;
      else if (run > 0)
      begin
        chk(run, exp_run[idx]);
        idx++;
        run = 0;
      end
    end
    chk(idx, 5);
    @(posedge clk);
    oc_force <= 3'h0;
    cycles(80);
    chk(hs_allow[0], 1'b1);
    @(posedge clk);
    uv_force <= 3'h1;
    @(posedge clk);
    uv_force <= 3'h0;
    cycles(5);
    chk(rail_on[0], 1'b0);
    wait_rail(0, n);
    chk_rng(n, HIC - 10, HIC + 4);
  endtask
  task automatic t_usb();
    @(posedge clk);
    usb_pin <= 2'h3;
    cycles(2);
    chk(usb_on, 2'h3);
    chk(vscale, 1'b0);
    @(posedge clk);
    usb_oc <= 2'h1;
    cycles(3);
    chk({usb1_oe, usb2_oe}, 2'h2);
    @(posedge clk);
    usb_oc <= 2'h2;
    cycles(3);
    chk({usb1_oe, usb2_oe}, 2'h1);
    @(posedge clk);
    usb_oc <= 2'h0;
    usb_pin <= 2'h0;
    cycles(3);
    chk(usb_on, 2'h0);
  endtask
  task automatic t_regs();
    int n;
    wb(1'b1, RSFC_OFS_ENABLE, 32'h0000_0008);
    @(posedge clk);
    ren <= 3'h0;
    bus_mode <= 1'b1;
    wb(1'b0, RSFC_OFS_ENABLE, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    wb(1'b1, RSFC_OFS_ENABLE, 32'h0000_001f);
    wb(1'b0, RSFC_OFS_ENABLE, 32'h0000_0000);
    chk(rd, 32'h0000_001f);
    wb(1'b0, 8'h10, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(usb_on, 2'h3);
    wait_rail(2, n);
    chk(rail_on, 3'h7);
    chk(vscale, 1'b1);
    wb(1'b0, RSFC_OFS_STATE, 32'h0000_0000);
    chk(rd, 32'h0000_023f);
    cycles(SS + GAP + 5);
  endtask
  task automatic t_bor();
    @(posedge clk);
    sense.main_lt_9v3 <= 1'b1;
    sense.main_gt_10v8 <= 1'b0;
    cycles(3);
    chk(warn_oe, 1'b1);
    chk(usb_on, 2'h0);
    chk(irq, 1'b1);
    @(posedge clk);
    sense.main_lt_9v3 <= 1'b0;
    wb(1'b0, RSFC_OFS_FAULT_STATUS_FIRST, 32'h0000_0000);
    chk(rd[RSFC_ST1_BROWNOUT], 1'b1);
    chk(rd[RSFC_ST1_HOT], 1'b0);
    wb(1'b0, RSFC_OFS_FAULT_STATUS_SECOND, 32'h0000_0000);
    chk(rd, 32'h0000_0019);
    cycles(3);
    chk(irq, 1'b0);
    chk(warn_oe, 1'b1);
    @(posedge clk);
    sense.main_gt_10v8 <= 1'b1;
    cycles(3);
    chk(warn_oe, 1'b0);
  endtask
  task automatic t_tsd();
    int n;
    wb(1'b1, RSFC_OFS_ENABLE, 32'h0000_001f);
    cycles(5 * (SS + GAP));
    @(posedge clk);
    sense.temp_warn <= 1'b1;
    sense.temp_trip <= 1'b1;
    sense.temp_cool <= 1'b0;
    cycles(3);
    chk({rail_on, usb_on, en_dis, warn_oe, irq}, 8'h07);
    wb(1'b0, RSFC_OFS_ENABLE, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    wb(1'b0, RSFC_OFS_FAULT_STATUS_FIRST, 32'h0000_0000);
    chk(rd[2:1], 2'h3);
    @(posedge clk);
    sense.temp_warn <= 1'b0;
    sense.temp_trip <= 1'b0;
    sense.temp_cool <= 1'b1;
    cycles(SS);
    chk({rail_on, warn_oe}, 4'h0);
    wb(1'b1, RSFC_OFS_ENABLE, 32'h0000_0001);
    wait_rail(0, n);
    chk_rng(n, 1, 12);
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_seq();
    t_ocp();
    t_usb();
    t_regs();
    t_bor();
    t_tsd();
    conclude();
  end
endmodule
